// ===== hdl/icd_capture.sv
// input capture block: dedicated counters, sync and trigger, fifos, apb slave
// assumes pins, ticks and sync events synchronous to clk; apb master on clk
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "icd_defs.svh"
// Notes on behaviour
// - nine independent capture modules, own interrupts
// - four deep fifo per module
// - own 16-bit counter, six clock sources
// - free run counts up, wraps to zero
// - capture writes current counter into fifo
// - sync mode: sync event clears counter
// - trigger mode: counter held until sync event
// - zero source, trigger clear: free running
// - nonzero source: trigger bit picks mode
// - up to thirty-one sync sources selectable
// - zero source, trigger set: software trigger
// - independent by default, pairs can cascade
// - even module low half, odd high
// - low half wrap increments high half
// - cascade works in every mode
// - mode field decodes edge and prescale captures
// - interrupt after one to four captures
// - overflow flag and buffer not empty bit
// - trigger mode: trigger status clear holds counter zero
module icd_capture #(
  parameter int NCH = 9,
  parameter int DEPTH = 4,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pins, time base ticks, sync sources
  input wire logic [NCH-1:0] capture_input_pin,
  input wire logic [4:0] timer_tick,
  input wire logic [31:0] sync_event,
  // per module interrupt pulses
  output logic [NCH-1:0] capture_irq
);
  import icd_pkg::*;

  // whole block state
  typedef struct packed {
    icd_chan_t [NCH-1:0] ch;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NCH-1:0] irq;
  } icd_top_t;
  icd_top_t st;
  icd_top_t next_st;

  logic [NCH-1:0] push;            // fifo write strobes
  logic [NCH-1:0] pop;             // fifo read strobes
  logic [NCH-1:0] empty;           // fifo empty
  logic [NCH-1:0] full;            // fifo full
  logic [NCH-1:0] act;             // module enabled
  logic [NCH-1:0] run;             // counter advances this cycle
  logic [NCH-1:0] clr;             // counter forced to zero
  logic [NCH-1:0] wrap;            // counter rolls over
  logic [NCH-1:0] cap;             // capture event
  logic [NCH-1:0][15:0] head;      // oldest fifo word
  logic [3:0] acc_ch;              // addressed module
  logic [3:0] acc_ofs;             // offset inside module window
  logic acc_hit;                   // module exists
  logic acc_done;                  // access completes this edge

  assign acc_ch = paddr[7:4];
  assign acc_ofs = {paddr[3:2], 2'b00};
  assign acc_hit = (int'(acc_ch) < NCH);
  assign acc_done = psel & penable & st.pready;

  // read word of one register of a module
  function automatic logic [31:0] rd_word(input icd_chan_t c, input logic bne,
                                          input logic [15:0] h, input logic [3:0] ofs);
    logic [31:0] r;
    r = '0;
    case (ofs)
      `ICD_OFS_CTL1: begin
        r[`ICD_C1_MODE +: 3] = c.mode;
        r[`ICD_C1_BNE] = bne;
        r[`ICD_C1_OVF] = c.ovf;
        r[`ICD_C1_IRQ +: 2] = c.per_irq;
        r[`ICD_C1_CLK +: 3] = c.clk_sel;
      end
      `ICD_OFS_CTL2: begin
        r[`ICD_C2_SYNC +: 5] = c.sync_sel;
        r[`ICD_C2_TSTAT] = c.trig_stat;
        r[`ICD_C2_TRIG] = c.trig_mode;
        r[`ICD_C2_CASC] = c.casc;
      end
      `ICD_OFS_BUF: r[15:0] = h;
      `ICD_OFS_CNT: r[15:0] = c.count;
      default: r = '0;
    endcase
    return r;
  endfunction

  // next state: bus access, then every module in index order
  always_comb begin
    icd_chan_t c;
    logic tick;
    logic trg;
    logic syn;
    logic sev;
    logic rise;
    logic fall;
    logic edge_ev;
    logic hi;
    int lo;
    c = '0;
    tick = 1'b0;
    trg = 1'b0;
    syn = 1'b0;
    sev = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    edge_ev = 1'b0;
    hi = 1'b0;
    lo = 0;
    next_st = st;
    push = '0;
    pop = '0;
    act = '0;
    run = '0;
    clr = '0;
    wrap = '0;
    cap = '0;
    next_st.irq = '0;
    // answer one cycle after setup; data and error registered
    next_st.pready = psel & ~penable;
    next_st.prdata = '0;
    next_st.pslverr = 1'b0;
    if (psel && !penable) begin
      if (!acc_hit) begin
        // unmapped module window
        next_st.pslverr = 1'b1;
      end else begin
        next_st.prdata = rd_word(st.ch[acc_ch], ~empty[acc_ch], head[acc_ch], acc_ofs);
      end
    end
    // writes and fifo pops take effect at the completing edge
    if (acc_done && acc_hit) begin
      if (pwrite) begin
        case (acc_ofs)
          `ICD_OFS_CTL1: begin
            next_st.ch[acc_ch].mode = pwdata[`ICD_C1_MODE +: 3];
            next_st.ch[acc_ch].per_irq = pwdata[`ICD_C1_IRQ +: 2];
            next_st.ch[acc_ch].clk_sel = pwdata[`ICD_C1_CLK +: 3];
          end
          `ICD_OFS_CTL2: begin
            next_st.ch[acc_ch].sync_sel = pwdata[`ICD_C2_SYNC +: 5];
            next_st.ch[acc_ch].trig_stat = pwdata[`ICD_C2_TSTAT];
            next_st.ch[acc_ch].trig_mode = pwdata[`ICD_C2_TRIG];
            next_st.ch[acc_ch].casc = pwdata[`ICD_C2_CASC];
          end
          default: begin
            // buffer and counter words are read only
          end
        endcase
      end else if (acc_ofs == `ICD_OFS_BUF) begin
        pop[acc_ch] = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      c = st.ch[i];
      lo = (i / 2) * 2;
      // upper module of a pair follows its lower partner when both agree
      hi = (i % 2 == 1) && c.casc && st.ch[lo].casc;
      // time base select: system clock or one of five timer ticks
      if (c.clk_sel == `ICD_CLK_SYS) begin
        tick = 1'b1;
      end else if (c.clk_sel <= `ICD_CLK_TMAX) begin
        tick = timer_tick[c.clk_sel];
      end else begin
        tick = 1'b0;
      end
      sev = sync_event[c.sync_sel];
      trg = c.trig_mode;
      syn = !trg && (c.sync_sel != 5'h00);
      // hardware trigger arms the counter; wins over a software clear
      if (trg && c.sync_sel != 5'h00 && sev && !hi) begin
        next_st.ch[i].trig_stat = 1'b1;
      end
      // edge detection and prescaler
      rise = capture_input_pin[i] & ~c.pin_prev;
      fall = ~capture_input_pin[i] & c.pin_prev;
      next_st.ch[i].pin_prev = capture_input_pin[i];
      edge_ev = 1'b0;
      case (c.mode)
        `ICD_M_EDGE: edge_ev = rise | fall;
        `ICD_M_FALL: edge_ev = fall;
        `ICD_M_RISE: edge_ev = rise;
        `ICD_M_DIV4: begin
          if (rise) begin
            edge_ev = (c.presc == `ICD_DIV4_LAST);
            next_st.ch[i].presc = edge_ev ? 4'h0 : c.presc + 4'h1;
          end
        end
        `ICD_M_DIV16: begin
          if (rise) begin
            edge_ev = (c.presc == `ICD_DIV16_LAST);
            next_st.ch[i].presc = edge_ev ? 4'h0 : c.presc + 4'h1;
          end
        end
        default: begin
          // off or unused codes
          edge_ev = 1'b0;
          next_st.ch[i].presc = 4'h0;
        end
      endcase
      if (c.mode != `ICD_M_DIV4 && c.mode != `ICD_M_DIV16) begin
        next_st.ch[i].presc = 4'h0;
      end
      if (hi) begin
        // high half counts on low wraps, captures with low events
        act[i] = act[lo];
        run[i] = wrap[lo];
        clr[i] = clr[lo];
        cap[i] = cap[lo];
      end else begin
        act[i] = (c.mode != `ICD_M_OFF) && (c.mode <= `ICD_M_DIV16);
        run[i] = act[i] & tick & (~trg | c.trig_stat);
        clr[i] = ~act[i] | (trg & ~c.trig_stat) | (syn & sev);
        cap[i] = act[i] & edge_ev & (~trg | c.trig_stat);
      end
      wrap[i] = run[i] & ~clr[i] & (c.count == `ICD_CNT_MAX);
      // counter update
      if (clr[i]) begin
        next_st.ch[i].count = 16'h0000;
      end else if (run[i]) begin
        next_st.ch[i].count = c.count + 16'h0001;
      end
      // capture into fifo, or flag the loss
      push[i] = cap[i] & ~full[i];
      next_st.ch[i].ovf = (c.ovf & act[i]) | (cap[i] & full[i]);
      // interrupt every n captures; every edge in edge mode
      if (!act[i] || hi) begin
        next_st.ch[i].irq_cnt = 2'h0;
      end else if (cap[i]) begin
        // at or past the limit, so lowering the limit mid-run cannot skip a wrap
        if (c.mode == `ICD_M_EDGE || c.irq_cnt >= c.per_irq) begin
          next_st.irq[i] = 1'b1;
          next_st.ch[i].irq_cnt = 2'h0;
        end else begin
          next_st.ch[i].irq_cnt = c.irq_cnt + 2'h1;
        end
      end
    end
  end

  // one fifo per module
  for (genvar g = 0; g < NCH; g++) begin : g_fifo
    icd_fifo #(
      .WIDTH(16),
      .DEPTH(DEPTH)
    ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .push(push[g]),
      .push_data(st.ch[g].count),
      .pop(pop[g]),
      .head(head[g]),
      .empty(empty[g]),
      .full(full[g])
    );
  end

  // state register; sync source resets to code 13, so reset leaves sync mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
      for (int i = 0; i < NCH; i++) begin
        st.ch[i].sync_sel <= `ICD_SYNC_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign capture_irq = st.irq;

  // checks on module 0 and pair 0/1
  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      (run[0] && !clr[0] && st.ch[0].count == `ICD_CNT_MAX) |=> (st.ch[0].count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

  property p_push;
    @(posedge clk) disable iff (!rst_b)
      cap[0] && !full[0] |-> push[0] ##1 !empty[0];
  endproperty
  a_push: assert property (p_push) else $error("capture not stored");

  property p_sync;
    @(posedge clk) disable iff (!rst_b)
      (act[0] && !st.ch[0].trig_mode && st.ch[0].sync_sel != 5'h00 && sync_event[st.ch[0].sync_sel])
      |=> (st.ch[0].count == 16'h0000);
  endproperty
  a_sync: assert property (p_sync) else $error("sync event did not clear counter");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (st.ch[0].trig_mode && !st.ch[0].trig_stat) [*2] |-> (st.ch[0].count == 16'h0000);
  endproperty
  a_hold: assert property (p_hold) else $error("untriggered counter not held clear");

  property p_soft;
    @(posedge clk) disable iff (!rst_b)
      (st.ch[0].trig_mode && !st.ch[0].trig_stat) |-> !push[0];
  endproperty
  a_soft: assert property (p_soft) else $error("capture before trigger");

  property p_rise;
    @(posedge clk) disable iff (!rst_b)
      (st.ch[0].mode == `ICD_M_RISE && !st.ch[0].trig_mode && capture_input_pin[0] && !st.ch[0].pin_prev)
      |-> (push[0] || full[0]);
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not captured");

  property p_fall_ign;
    @(posedge clk) disable iff (!rst_b)
      (st.ch[0].mode == `ICD_M_RISE && !capture_input_pin[0] && st.ch[0].pin_prev) |-> !cap[0];
  endproperty
  a_fall_ign: assert property (p_fall_ign) else $error("falling edge captured in rise mode");

  property p_casc;
    @(posedge clk) disable iff (!rst_b)
      (NCH > 1 && st.ch[1].casc && st.ch[0].casc && wrap[0] && !clr[0])
      |=> (st.ch[1].count == $past(st.ch[1].count) + 16'h0001);
  endproperty
  a_casc: assert property (p_casc) else $error("high half missed low wrap");

  property p_pair_cap;
    @(posedge clk) disable iff (!rst_b)
      (NCH > 1 && st.ch[1].casc && st.ch[0].casc) |-> (cap[1] == cap[0]);
  endproperty
  a_pair_cap: assert property (p_pair_cap) else $error("pair halves captured apart");

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      (cap[0] && st.ch[0].mode == `ICD_M_RISE && st.ch[0].per_irq == 2'h0) |=> capture_irq[0];
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt on capture");

  property p_ovf;
    @(posedge clk) disable iff (!rst_b)
      (cap[0] && full[0]) |=> st.ch[0].ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule // icd_capture

// ===== hdl/icd_defs.svh
// constants for the input capture block: offsets, field positions, codes
// assumes inclusion by bare name from files that need the register layout
`ifndef ICD_DEFS_SVH
`define ICD_DEFS_SVH
// byte offsets inside one module window of 16 bytes
`define ICD_OFS_CTL1 4'h0
`define ICD_OFS_CTL2 4'h4
`define ICD_OFS_BUF 4'h8
`define ICD_OFS_CNT 4'hC
// capture_control_one field positions
`define ICD_C1_MODE 0
`define ICD_C1_BNE 3
`define ICD_C1_OVF 4
`define ICD_C1_IRQ 5
`define ICD_C1_CLK 10
// capture_control_two field positions
`define ICD_C2_SYNC 0
`define ICD_C2_TSTAT 6
`define ICD_C2_TRIG 7
`define ICD_C2_CASC 8
// reset value and counter maximum
`define ICD_SYNC_RST 5'h0D
`define ICD_CNT_MAX 16'hFFFF
// capture mode codes
`define ICD_M_OFF 3'h0
`define ICD_M_EDGE 3'h1
`define ICD_M_FALL 3'h2
`define ICD_M_RISE 3'h3
`define ICD_M_DIV4 3'h4
`define ICD_M_DIV16 3'h5
// clock source codes
`define ICD_CLK_SYS 3'h7
`define ICD_CLK_TMAX 3'h4
// prescaler terminal counts
`define ICD_DIV4_LAST 4'h3
`define ICD_DIV16_LAST 4'hF
`endif

// ===== hdl/icd_fifo.sv
// capture value fifo: small memory with registered head word
// assumes one clock, synchronous active low reset; push when full is dropped
`timescale 1ns/1ps
module icd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // write side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // read side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // whole fifo state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic [WIDTH-1:0] head;
  } icd_fifo_t;
  icd_fifo_t st;
  icd_fifo_t next_st;

  // pop first, then push; head tracks the next oldest word
  always_comb begin
    next_st = st;
    if (pop && st.cnt != '0) begin
      next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
      next_st.cnt = next_st.cnt - 1'b1;
    end
    if (push && st.cnt != (PW + 1)'(DEPTH)) begin
      next_st.mem[st.wp] = push_data;
      next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
      next_st.cnt = next_st.cnt + 1'b1;
    end
    next_st.head = next_st.mem[next_st.rp];
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.head;
  assign empty = (st.cnt == '0);
  assign full = (st.cnt == (PW + 1)'(DEPTH));
endmodule // icd_fifo

// ===== hdl/icd_pkg.sv
// types shared by the input capture block
// assumes nothing of its surroundings
package icd_pkg;
  // per module control and run state
  typedef struct packed {
    logic [2:0] clk_sel;   // time base select
    logic [1:0] per_irq;   // captures per interrupt
    logic [2:0] mode;      // capture mode select
    logic ovf;             // capture overflow
    logic casc;            // cascade enable
    logic trig_mode;       // trigger mode select
    logic trig_stat;       // trigger status
    logic [4:0] sync_sel;  // sync source select
    logic [15:0] count;    // capture counter
    logic pin_prev;        // last pin sample
    logic [3:0] presc;     // rising edge prescaler
    logic [1:0] irq_cnt;   // captures since last interrupt
  } icd_chan_t;
endpackage

// ===== tb/icd_capture_bench.sv
// self-checking bench for the input capture block over apb
// assumes the pin model as far side; counters frozen by holding ticks low
`timescale 1ns/1ps
`include "icd_defs.svh"
module icd_capture_bench;
  // bench driven signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0] timer_tick = 5'h00;
  logic [31:0] sync_event = 32'h0000_0000;
  // design outputs and last apb answer
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] pin;
  logic [8:0] irq;
  logic [31:0] rd;
  logic err;
  // counters and random state
  int num_errors = 0;
  int n_checks = 0;
  int n_irq = 0;
  int cyc = 0;
  int seed = 72;
  int m, k, per, n, caps;
  int npul[6] = '{0, 2, 4, 4, 16, 16};

  // 125 mhz clock
  always #4 clk = ~clk;

  icd_capture #(.NCH(9), .DEPTH(4), .AW(8)) i_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .timer_tick(timer_tick), .sync_event(sync_event),
    .capture_irq(irq));
  icd_pin_model i_pin (.clk(clk), .pin(pin));

  // count irq pulses; cut a hang short
  always @(posedge clk) begin
    n_irq <= n_irq + $countones(irq);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  // compare and report
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  // byte address of a register in module mi
  function automatic logic [7:0] ad(input int mi, input logic [3:0] o);
    return 8'(mi * 16) | {4'h0, o};
  endfunction

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int mi, input logic [3:0] o, input logic [31:0] d);
    apb(1'b1, ad(mi, o), d);
  endtask

  task automatic rdchk(input string s, input int mi, input logic [3:0] o, input logic [31:0] e);
    apb(1'b0, ad(mi, o), 32'h0000_0000);
    chk(s, e, rd);
  endtask

  // n counts on time base 0
  task automatic tick(input int t);
    @(posedge clk);
    timer_tick[0] <= 1'b1;
    repeat (t) @(posedge clk);
    timer_tick[0] <= 1'b0;
  endtask

  // one pulse on sync source 1
  task automatic sync();
    @(posedge clk);
    sync_event[1] <= 1'b1;
    @(posedge clk);
    sync_event[1] <= 1'b0;
  endtask

  // captures per pulse train in each mode
  function automatic int exp_caps(input int md, input int np);
    case (md)
      1: return 2 * np;
      4: return np / 4;
      5: return np / 16;
      default: return np;
    endcase
  endfunction

  // edge mode interrupts on every capture
  function automatic int exp_irq(input int md, input int c, input int p);
    return (md == 1) ? c : c / (p + 1);
  endfunction

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // reset values in all nine modules
    for (int i = 0; i < 9; i++) begin
      rdchk("ctl1 reset", i, `ICD_OFS_CTL1, 32'h0000_0000);
      rdchk("ctl2 reset", i, `ICD_OFS_CTL2, {27'h0, `ICD_SYNC_RST});
    end
    done("reset");
    m = 2 + ($unsigned($random(seed)) % 7);
    // free run on the system clock: three cycles between samples
    wr(m, `ICD_OFS_CTL2, 32'h0000_0000);
    wr(m, `ICD_OFS_CTL1, 32'h0000_1C03);
    apb(1'b0, ad(m, `ICD_OFS_CNT), 32'h0000_0000);
    k = rd;
    rdchk("free run", m, `ICD_OFS_CNT, (k + 3) & 32'h0000_FFFF);
    done("free run");
    // every capture mode, sync clear, frozen counter
    for (int md = 1; md < 6; md++) begin
      per = $unsigned($random(seed)) % 4;
      k = 1 + $unsigned($random(seed)) % 20;
      caps = exp_caps(md, npul[md]);
      wr(m, `ICD_OFS_CTL1, 32'h0000_0000);
      wr(m, `ICD_OFS_CTL2, 32'h0000_0001);
      wr(m, `ICD_OFS_CTL1, md | (per << 5));
      tick(7);
      sync();
      tick(k);
      n = n_irq;
      i_pin.pulse(m, npul[md]);
      chk("irq count", exp_irq(md, caps, per), n_irq - n);
      rdchk("ctl1 full", m, `ICD_OFS_CTL1, md | (per << 5) | 8);
      repeat (caps) rdchk("fifo", m, `ICD_OFS_BUF, k);
      rdchk("ctl1 empty", m, `ICD_OFS_CTL1, md | (per << 5));
    end
    done("modes");
    // remaining single module tests run on module 0, where the design checks look
    m = 0;
    // fifth capture overflows the four deep fifo
    wr(m, `ICD_OFS_CTL1, 32'h0000_0000);
    wr(m, `ICD_OFS_CTL1, 32'h0000_0003);
    i_pin.pulse(m, 5);
    rdchk("overflow", m, `ICD_OFS_CTL1, 32'h0000_001B);
    repeat (4) rdchk("kept", m, `ICD_OFS_BUF, 32'h0000_0000);
    done("overflow");
    // hardware trigger holds the counter until the sync pulse
    wr(m, `ICD_OFS_CTL1, 32'h0000_0000);
    wr(m, `ICD_OFS_CTL2, 32'h0000_0081);
    wr(m, `ICD_OFS_CTL1, 32'h0000_0003);
    tick(5);
    rdchk("held", m, `ICD_OFS_CNT, 32'h0000_0000);
    i_pin.pulse(m, 1);
    rdchk("no capture", m, `ICD_OFS_CTL1, 32'h0000_0003);
    sync();
    rdchk("status", m, `ICD_OFS_CTL2, 32'h0000_00C1);
    tick(k);
    rdchk("running", m, `ICD_OFS_CNT, k);
    done("trigger");
    // software trigger
    wr(m, `ICD_OFS_CTL1, 32'h0000_0000);
    wr(m, `ICD_OFS_CTL2, 32'h0000_0080);
    wr(m, `ICD_OFS_CTL1, 32'h0000_0003);
    tick(5);
    rdchk("sw held", m, `ICD_OFS_CNT, 32'h0000_0000);
    wr(m, `ICD_OFS_CTL2, 32'h0000_00C0);
    tick(k);
    rdchk("sw run", m, `ICD_OFS_CNT, k);
    done("software trigger");
    // cascade pair 0 and 1, low half wraps once
    wr(1, `ICD_OFS_CTL2, 32'h0000_0101);
    wr(0, `ICD_OFS_CTL2, 32'h0000_0101);
    wr(1, `ICD_OFS_CTL1, 32'h0000_0003);
    wr(0, `ICD_OFS_CTL1, 32'h0000_0003);
    sync();
    tick(65536 + k);
    i_pin.pulse(0, 1);
    rdchk("low half", 0, `ICD_OFS_BUF, k);
    rdchk("high half", 1, `ICD_OFS_BUF, 32'h0000_0001);
    done("cascade");
    // module index past the last one is refused
    apb(1'b1, 8'h90, 32'h0000_FFFF);
    chk("slverr wr", 32'h0000_0001, {31'h0, err});
    apb(1'b0, 8'h90, 32'h0000_0000);
    chk("slverr rd", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    done("unmapped");
    wrap_up();
  end
endmodule // icd_capture_bench

// ===== tb/icd_pin_model.sv
// partner model: drives the nine capture input pins with clean pulses
// assumes the bench calls pulse from its own process and supplies clk
`timescale 1ns/1ps
module icd_pin_model (
  // clock
  input wire logic clk,
  // capture pins, idle low
  output logic [8:0] pin
);
  // all pins start idle low
  initial pin = 9'h000;

  // n full pulses on pin m, each level held two cycles
  task automatic pulse(input int m, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      pin[m] <= 1'b1;
      repeat (2) @(posedge clk);
      pin[m] <= 1'b0;
    end
    // give the last edge time to reach the fifo and irq
    repeat (4) @(posedge clk);
  endtask
endmodule // icd_pin_model
